// >>> bench/prcfg_array_model.sv
// Array side model: logs requests, answers reads in order
module prcfg_array_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic        reqWrite,
   input  wire logic [21:0] reqAddr,
   input  wire logic [15:0] reqData,
   input  wire logic [1:0]  reqBe,
   output logic             rdValid,
   input  wire logic        rdReady,
   output logic [15:0]      rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [21:0] logAddr[$];
   logic        logWr[$];
   logic [15:0] logData[$];
   logic [1:0]  logBe[$];
   logic [15:0] pend[$];
   // Idle data inverts every cycle, alternating the last word and its inverse
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reqReady <= 1'b1;
         rdValid <= 1'b0;
         rdData <= 16'hFFFF;
         pend.delete();
      end else begin
         if (rdValid && rdReady)
            pend.delete(0);
         if (reqValid && reqReady) begin
            logAddr.push_back(reqAddr);
            logWr.push_back(reqWrite);
            logData.push_back(reqData);
            logBe.push_back(reqBe);
            if (!reqWrite)
               pend.push_back(reqAddr[15:0] ^ 16'h5A5A);
         end
         reqReady <= slow ? ~reqReady : 1'b1;
         rdValid <= (pend.size() != 0);
         rdData <= (pend.size() != 0) ? pend[0] : ~rdData;
      end
   end
endmodule : prcfg_array_model

// >>> bench/testbench.sv
// Self-checking bench for the configuration register block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, mclk = 0, run = 0, slow = 0;
   logic        sel = 0, ceN = 1, advN = 1, weN = 1, oeN = 1, lbN = 1, hbN = 1;
   logic [21:0] a = '0;
   logic [15:0] dq = '0;
   logic [15:0] dqOut, busReg, refReg, reqData, rdData;
   logic [21:0] reqAddr;
   logic [1:0]  drv, reqBe;
   logic        dqOeN, waitOut, syncMode, reqValid, reqReady, reqWrite, rdValid, rdReady;
   int          mismatches = 0, n_checks = 0, cycles = 0;
   always #12.5 clk = ~clk;
   // Link clock stands still outside frames
   always begin
      #100;
      if (run)
         mclk = ~mclk;
   end
   prcfg_top DUT (.core_clk(clk), .sys_rst(rst), .memClk(mclk), .cfgSpaceSelect(sel),
      .chipEnableN(ceN), .addrValidStrobeN(advN), .writeEnableN(weN), .outputEnableN(oeN),
      .lowByteEnableN(lbN), .highByteEnableN(hbN), .addrIn(a), .dqIn(dq), .dqOut(dqOut),
      .dqOeN(dqOeN), .waitOut(waitOut), .driveStrength(drv), .syncMode(syncMode),
      .busSetupReg(busReg), .refreshSetupReg(refReg), .arrReqValid(reqValid),
      .arrReqReady(reqReady), .arrReqWrite(reqWrite), .arrReqAddr(reqAddr),
      .arrReqData(reqData), .arrReqByteEnN(reqBe), .arrRdValid(rdValid),
      .arrRdReady(rdReady), .arrRdData(rdData));
   prcfg_array_model arrayModel (.clk(clk), .rst(rst), .slow(slow), .reqValid(reqValid),
      .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
      .reqBe(reqBe), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   // Strobe levels held 4 cycles, above the 3 cycle minimum
   task automatic pins(input logic s, c, v, w, o, input logic [21:0] ad);
      sel = s;
      ceN = c;
      advN = v;
      weN = w;
      oeN = o;
      a = ad;
      repeat (4) @(negedge clk);
   endtask : pins
   // Address changes after the first rising strobe must not load
   task automatic aload(input logic [21:0] ad);
      pins(1, 0, 0, 0, 1, ad);
      pins(1, 0, 1, 0, 1, ad);
      pins(1, 0, 1, 0, 1, ~ad);
      pins(0, 1, 1, 1, 1, '0);
   endtask : aload
   task automatic t_reset;
      check(busReg, 16'h9D4F);
      check(refReg, 16'h0070);
      check(syncMode, 0);
      check(drv, 0);
      check(waitOut, 0);
      check(busReg[13:11], 3);
      check(busReg[3:0], 4'hF);
      check(dqOeN, 1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_load;
      aload(22'h2B9D6A);
      check(busReg, 16'h9D6A);
      check(refReg, 16'h0070);
      check(drv, 2'h2);
      aload(22'h170015);
      check(refReg, 16'h0015);
      check(busReg, 16'h9D6A);
      pins(1, 0, 1, 1, 0, 22'h3FFFFF);
      check(dqOut, 16'h9D6A);
      check(dqOeN, 0);
      pins(1, 0, 1, 1, 0, 22'h37FFFF);
      check(dqOut, 16'h0015);
      pins(0, 1, 1, 1, 1, '0);
      check(dqOeN, 1);
      $display("t_load done");
   endtask : t_load
   task automatic t_array;
      int n;
      n = arrayModel.logAddr.size();
      lbN = 0;
      dq = 16'hC3E1;
      pins(0, 0, 0, 0, 1, 22'h012345);
      pins(0, 0, 1, 0, 1, 22'h012345);
      pins(0, 1, 1, 1, 1, 22'h012345);
      check(arrayModel.logWr[n], 1);
      check(arrayModel.logAddr[n], 22'h012345);
      check(arrayModel.logData[n], 16'hC3E1);
      check(arrayModel.logBe[n], 2'h2);
      check(refReg, 16'h0015);
      hbN = 0;
      pins(0, 0, 0, 1, 0, 22'h000777);
      repeat (4) @(negedge clk);
      check(dqOut, 16'h0777 ^ 16'h5A5A);
      check(arrayModel.logWr[n+1], 0);
      pins(0, 1, 1, 1, 1, '0);
      $display("t_array done");
   endtask : t_array
   task automatic t_sync;
      int n;
      aload(22'h081D42);
      check(syncMode, 1);
      pins(1, 0, 0, 0, 1, 22'h030033);
      run = 1;
      // Chip enable held low across the whole clocked write
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      run = 0;
      @(negedge clk);
      pins(0, 1, 1, 1, 1, '0);
      check(refReg, 16'h0033);
      n = arrayModel.logAddr.size();
      slow = 1;
      pins(0, 0, 0, 1, 0, 22'h000105);
      run = 1;
      @(posedge mclk);
      repeat (3) @(negedge clk);
      advN = 1;
      @(negedge clk);
      check(waitOut, 1);
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      // Tenth word of the wrapped burst stands until the next link edge
      check(dqOut, 16'h0106 ^ 16'h5A5A);
      check(dqOeN, 0);
      check(waitOut, 0);
      run = 0;
      @(negedge clk);
      pins(0, 1, 1, 1, 1, '0);
      repeat (100) @(negedge clk);
      for (int i = 0; i < 8; i++)
         check(arrayModel.logAddr[n+i], 22'h000100 + ((5 + i) % 8));
      slow = 0;
      $display("t_sync done");
   endtask : t_sync
   // Write burst crosses the 8-word block that a read would wrap in
   task automatic t_wburst;
      int n;
      n = arrayModel.logAddr.size();
      dq = 16'h6C93;
      pins(0, 0, 0, 0, 1, 22'h000105);
      run = 1;
      @(posedge mclk);
      repeat (3) @(negedge clk);
      advN = 1;
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      run = 0;
      @(negedge clk);
      pins(0, 1, 1, 1, 1, '0);
      repeat (20) @(negedge clk);
      check(arrayModel.logAddr.size(), n + 4);
      for (int i = 0; i < 4; i++) begin
         check(arrayModel.logWr[n+i], 1);
         check(arrayModel.logAddr[n+i], 22'h000105 + i);
         check(arrayModel.logData[n+i], 16'h6C93);
      end
      $display("t_wburst done");
   endtask : t_wburst
   initial begin
      repeat (8) @(negedge clk);
      rst = 0;
      @(negedge clk);
      t_reset();
      t_load();
      t_array();
      t_sync();
      t_wburst();
      final_report();
   end
endmodule : testbench

// >>> rtl/prcfg_cfg.svh
// Field positions, reset values and sizes of the configuration register block
`ifndef PRCFG_CFG_SVH
`define PRCFG_CFG_SVH
`define PRCFG_BUS_RESET    16'h9D4F
`define PRCFG_REF_RESET    16'h0070
`define PRCFG_ADDR_W       22
`define PRCFG_FIFO_DEPTH   32
`define PRCFG_SEL_BIT      19
`define PRCFG_BL_HI        2
`define PRCFG_BL_LO        0
`define PRCFG_WRAP_BIT     3
`define PRCFG_DRV_HI       5
`define PRCFG_DRV_LO       4
`define PRCFG_WAITCFG_BIT  8
`define PRCFG_WAITPOL_BIT  10
`define PRCFG_LAT_HI       13
`define PRCFG_LAT_LO       11
`define PRCFG_OPMODE_BIT   15
`define PRCFG_BL_4         3'h1
`define PRCFG_BL_8         3'h2
`define PRCFG_BL_16        3'h3
`define PRCFG_BL_CONT      3'h7
`endif

// >>> rtl/prcfg_pkg.sv
// Types shared by the configuration register block
package prcfg_pkg;
   typedef enum logic [1:0] {BST_IDLE, BST_LAT, BST_DATA, BST_DRAIN} prcfg_burst_t;
   typedef logic [15:0] prcfg_word_t;
endpackage : prcfg_pkg

// >>> rtl/prcfg_top.sv
// Configuration registers, pin front end and burst sequencer of the pseudo-static RAM
// Notes on behaviour
// - Registers load defaults at reset; host changes in standby.
// - Select high turns writes into register loads.
// - Select low routes accesses to the array.
// - Register value comes from the address pins.
// - Async load on first rising strobe; byte enables ignored.
// - Address bit 19 picks bus or refresh register.
// - Register read drives selected sixteen bits on data.
// - Bus setup register resets to 9D4F.
// - Burst length field gives 4, 8, 16, continuous.
// - Continuous burst counts on, rolling over to zero.
// - Wrap bit one means sequential, overriding length.
// - Wrapped burst cycles modulo length inside aligned block.
// - Wrap and length only affect reads.
// - Impedance field sets output drive strength.
// - Wait timing bit sets wait lead over data.
// - Wait polarity bit sets asserted level.
// - Operating mode bit picks synchronous or asynchronous.
// - Three-bit latency code, default three.
// - Code N gives N clocks to first data.
// - Refresh setup register resets to 0070.
`include "prcfg_cfg.svh"

module prcfg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = `PRCFG_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_q;
   logic [AW:0]      rdPtr_q;

   // Depth must be a power of two so the extra pointer bit marks full
   assign outValid = wrPtr_q != rdPtr_q;
   assign inReady  = (wrPtr_q - rdPtr_q) != FULL_CNT;
   assign outData  = mem[rdPtr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (inValid && inReady) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && inReady) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outValid && outReady) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule : prcfg_fifo

module prcfg_top import prcfg_pkg::*; #(
   parameter int ADDR_W = `PRCFG_ADDR_W,
   parameter int DEPTH  = `PRCFG_FIFO_DEPTH
) (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              memClk,
   input  wire logic              cfgSpaceSelect,
   input  wire logic              chipEnableN,
   input  wire logic              addrValidStrobeN,
   input  wire logic              writeEnableN,
   input  wire logic              outputEnableN,
   input  wire logic              lowByteEnableN,
   input  wire logic              highByteEnableN,
   input  wire logic [ADDR_W-1:0] addrIn,
   input  wire logic [15:0]       dqIn,
   output logic [15:0]            dqOut,
   output logic                   dqOeN,
   output logic                   waitOut,
   output logic [1:0]             driveStrength,
   output logic                   syncMode,
   output logic [15:0]            busSetupReg,
   output logic [15:0]            refreshSetupReg,
   output logic                   arrReqValid,
   input  wire logic              arrReqReady,
   output logic                   arrReqWrite,
   output logic [ADDR_W-1:0]      arrReqAddr,
   output logic [15:0]            arrReqData,
   output logic [1:0]             arrReqByteEnN,
   input  wire logic              arrRdValid,
   output logic                   arrRdReady,
   input  wire logic [15:0]       arrRdData
);
   localparam int PW = 8 + ADDR_W + 16;
   localparam int IW = $clog2(DEPTH + 1);
   localparam logic [IW-1:0] INFL_MAX = IW'(DEPTH);
   // Strobes idle high so no edge is seen at the release of reset
   localparam logic [PW-1:0] PINS_IDLE = {2'h0, 6'h3F, (PW-8)'(0)};

   logic [PW-1:0]     pinsM_q;
   logic [PW-1:0]     pinsS_q;
   logic [PW-1:0]     pinsP_q;
   logic              clkS, selS, ceNS, advNS, weNS, oeNS, lbNS, ubNS;
   logic              clkP, selP, ceNP, advNP, weNP, oeNP, lbNP, ubNP;
   logic [ADDR_W-1:0] addrS, addrP, addrW;
   logic [15:0]       dqS, dqP;
   prcfg_word_t       bus_q, ref_q, dqOut_q;
   prcfg_burst_t      state_q;
   logic [2:0]        latCnt_q, latCode, blField;
   logic [ADDR_W-1:0] burstAddr_q, rdAddr_q, wrapMask, nextRdAddr;
   logic [IW-1:0]     inflight_q;
   logic [3:0]        edgeCnt_q;
   logic              syncSeen_q, armed_q, bWrite_q, rdDone_q, dqOeN_q;
   logic              waitLvl_q, waitPre_q, waitAct;
   logic              reqValid_q, reqWrite_q;
   logic [ADDR_W-1:0] reqAddr_q;
   logic [15:0]       reqData_q;
   logic [1:0]        reqBe_q;
   logic              clkRise, syncStart, cfgSyncWr, wrEdge, asyncWrEdge;
   logic              cfgAsyncWr, arrAsyncWr, cfgWr, regRead, wrapOn;
   logic              inBurst, burstStart, readPresent, burstWrPush, burstRdIssue;
   logic              asyncRdOn, asyncRdIssue, reqFree, reqIssueRd, popAny;
   logic              fifoOutValid;
   logic [15:0]       fifoOutData;

   // Three flops on every pin, link clock included
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinsM_q <= PINS_IDLE;
         pinsS_q <= PINS_IDLE;
         pinsP_q <= PINS_IDLE;
      end else begin
         pinsM_q <= {memClk, cfgSpaceSelect, chipEnableN, addrValidStrobeN, writeEnableN,
                     outputEnableN, lowByteEnableN, highByteEnableN, addrIn, dqIn};
         pinsS_q <= pinsM_q;
         pinsP_q <= pinsS_q;
      end
   end

   assign {clkS, selS, ceNS, advNS, weNS, oeNS, lbNS, ubNS, addrS, dqS} = pinsS_q;
   assign {clkP, selP, ceNP, advNP, weNP, oeNP, lbNP, ubNP, addrP, dqP} = pinsP_q;

   assign clkRise   = clkS & ~clkP;
   assign syncMode  = ~bus_q[`PRCFG_OPMODE_BIT];
   assign syncStart = clkRise & ~ceNS & ~advNS & syncMode;
   assign cfgSyncWr = syncStart & selS & ~weNS;
   assign wrEdge    = (advNS & ~advNP) | (ceNS & ~ceNP) | (weNS & ~weNP);
   // Only the first rising strobe of a write cycle loads; byte enables unused
   assign asyncWrEdge = wrEdge & ~ceNP & ~weNP & armed_q & ~syncSeen_q;
   assign cfgAsyncWr  = asyncWrEdge & selP;
   assign arrAsyncWr  = asyncWrEdge & ~selP;
   assign cfgWr       = cfgSyncWr | cfgAsyncWr;
   assign addrW       = cfgSyncWr ? addrS : addrP;
   assign regRead     = selS & ~ceNS & ~oeNS & weNS;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         armed_q    <= 1'b1;
         syncSeen_q <= 1'b0;
      end else begin
         if (asyncWrEdge) begin
            armed_q <= 1'b0;
         end else if (ceNS || weNS) begin
            armed_q <= 1'b1;
         end
         // A clocked cycle must not also load again when its strobes rise
         if (ceNS && ceNP) begin
            syncSeen_q <= 1'b0;
         end else if (clkRise && !ceNS) begin
            syncSeen_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_q <= `PRCFG_BUS_RESET;
         ref_q <= `PRCFG_REF_RESET;
      end else if (cfgWr) begin
         if (addrW[`PRCFG_SEL_BIT]) begin
            bus_q <= addrW[15:0];
         end else begin
            ref_q <= addrW[15:0];
         end
      end
   end

   assign latCode = bus_q[`PRCFG_LAT_HI:`PRCFG_LAT_LO];
   assign blField = bus_q[`PRCFG_BL_HI:`PRCFG_BL_LO];

   // Wrap mask from burst length; no-wrap bit overrides any length
   always_comb begin
      wrapMask = '0;
      unique case (blField)
         `PRCFG_BL_4:  wrapMask = ADDR_W'(4'h3);
         `PRCFG_BL_8:  wrapMask = ADDR_W'(4'h7);
         `PRCFG_BL_16: wrapMask = ADDR_W'(4'hF);
         default:      wrapMask = '0;
      endcase
   end
   assign wrapOn = ~bus_q[`PRCFG_WRAP_BIT] & (wrapMask != '0);
   assign nextRdAddr = wrapOn ?
                       ((burstAddr_q & ~wrapMask) | ((burstAddr_q + 1'b1) & wrapMask))
                       : burstAddr_q + 1'b1;

   assign inBurst      = (state_q == BST_LAT) || (state_q == BST_DATA);
   assign burstStart   = syncStart & ~selS & (state_q == BST_IDLE);
   assign readPresent  = clkRise & inBurst & ~ceNS & ~bWrite_q &
                         (((state_q == BST_LAT) && (latCnt_q <= 3'h1)) || (state_q == BST_DATA));
   assign burstWrPush  = clkRise & (state_q == BST_DATA) & ~ceNS & bWrite_q;
   assign burstRdIssue = inBurst & ~ceNS & ~bWrite_q & ~reqValid_q & (inflight_q < INFL_MAX);
   assign asyncRdOn    = ~selS & ~ceNS & ~oeNS & weNS & ~syncMode & (state_q == BST_IDLE);
   assign asyncRdIssue = asyncRdOn & ~reqValid_q & (inflight_q == '0) &
                         (~rdDone_q | (addrS != rdAddr_q));
   assign reqFree      = ~reqValid_q | arrReqReady;
   assign reqIssueRd   = burstRdIssue | asyncRdIssue;
   // Outside a burst anything left over is drained; only an asynchronous read in idle passes the popped word to dqOut
   assign popAny       = fifoOutValid & (readPresent | ~inBurst);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q  <= BST_IDLE;
         latCnt_q <= 3'h0;
         bWrite_q <= 1'b0;
      end else begin
         unique case (state_q)
            BST_IDLE: begin
               if (burstStart) begin
                  state_q  <= BST_LAT;
                  latCnt_q <= latCode;
                  bWrite_q <= ~weNS;
               end
            end
            BST_LAT: begin
               if (ceNS) begin
                  state_q <= BST_DRAIN;
               end else if (clkRise) begin
                  latCnt_q <= latCnt_q - 1'b1;
                  if (latCnt_q <= 3'h1) begin
                     state_q <= BST_DATA;
                  end
               end
            end
            BST_DATA: begin
               if (ceNS) begin
                  state_q <= BST_DRAIN;
               end
            end
            BST_DRAIN: begin
               if (inflight_q == '0) begin
                  state_q <= BST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         burstAddr_q <= '0;
      end else if (burstStart) begin
         burstAddr_q <= addrS;
      end else if (burstWrPush) begin
         burstAddr_q <= burstAddr_q + 1'b1;
      end else if (burstRdIssue) begin
         burstAddr_q <= nextRdAddr;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdDone_q <= 1'b0;
         rdAddr_q <= '0;
      end else if (asyncRdIssue) begin
         rdDone_q <= 1'b1;
         rdAddr_q <= addrS;
      end else if (!asyncRdOn) begin
         rdDone_q <= 1'b0;
      end
   end

   // Writes arriving while the request slot is busy are lost
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reqValid_q <= 1'b0;
         reqWrite_q <= 1'b0;
         reqAddr_q  <= '0;
         reqData_q  <= 16'h0000;
         reqBe_q    <= 2'h3;
      end else if (arrAsyncWr && reqFree) begin
         reqValid_q <= 1'b1;
         reqWrite_q <= 1'b1;
         reqAddr_q  <= addrP;
         reqData_q  <= dqP;
         reqBe_q    <= {ubNP, lbNP};
      end else if (burstWrPush && reqFree) begin
         reqValid_q <= 1'b1;
         reqWrite_q <= 1'b1;
         reqAddr_q  <= burstAddr_q;
         reqData_q  <= dqS;
         reqBe_q    <= {ubNS, lbNS};
      end else if (reqIssueRd) begin
         reqValid_q <= 1'b1;
         reqWrite_q <= 1'b0;
         reqAddr_q  <= burstRdIssue ? burstAddr_q : addrS;
         reqBe_q    <= 2'h0;
      end else if (arrReqReady) begin
         reqValid_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inflight_q <= '0;
      end else begin
         inflight_q <= inflight_q + IW'(reqIssueRd) - IW'(popAny);
      end
   end

   prcfg_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH)
   ) u_rdFifo (
      .clk      (core_clk),
      .rst      (sys_rst),
      .inValid  (arrRdValid),
      .inReady  (arrRdReady),
      .inData   (arrRdData),
      .outValid (fifoOutValid),
      .outReady (popAny),
      .outData  (fifoOutData)
   );

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dqOut_q <= 16'h0000;
         dqOeN_q <= 1'b1;
      end else begin
         if (regRead) begin
            dqOut_q <= addrS[`PRCFG_SEL_BIT] ? bus_q : ref_q;
         end else if (popAny && (readPresent || asyncRdOn)) begin
            dqOut_q <= fifoOutData;
         end
         dqOeN_q <= ~(regRead | asyncRdOn |
                      (inBurst & ~bWrite_q & ~ceNS & ~oeNS & ~selS));
      end
   end

   // Early copy leads the first data word by one link clock; in the data phase both copies move with data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         waitLvl_q <= 1'b0;
         waitPre_q <= 1'b0;
      end else if (burstStart) begin
         waitLvl_q <= 1'b1;
         waitPre_q <= 1'b1;
      end else if (!inBurst) begin
         waitLvl_q <= 1'b0;
         waitPre_q <= 1'b0;
      end else if (clkRise) begin
         if (((state_q == BST_LAT) && (latCnt_q <= 3'h1)) || (state_q == BST_DATA)) begin
            waitLvl_q <= ~bWrite_q & ~fifoOutValid;
         end
         if (state_q == BST_LAT) begin
            waitPre_q <= latCnt_q > 3'h2;
         end else begin
            waitPre_q <= ~bWrite_q & ~fifoOutValid;
         end
      end
   end

   assign waitAct = inBurst & (bus_q[`PRCFG_WAITCFG_BIT] ? waitPre_q : waitLvl_q);
   assign waitOut = waitAct == bus_q[`PRCFG_WAITPOL_BIT];

   assign dqOut           = dqOut_q;
   assign dqOeN           = dqOeN_q;
   assign driveStrength   = bus_q[`PRCFG_DRV_HI:`PRCFG_DRV_LO];
   assign busSetupReg     = bus_q;
   assign refreshSetupReg = ref_q;
   assign arrReqValid     = reqValid_q;
   assign arrReqWrite     = reqWrite_q;
   assign arrReqAddr      = reqAddr_q;
   assign arrReqData      = reqData_q;
   assign arrReqByteEnN   = reqBe_q;

   // Helper for the latency check only
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         edgeCnt_q <= 4'h0;
      end else if (burstStart) begin
         edgeCnt_q <= 4'h0;
      end else if (clkRise && inBurst) begin
         edgeCnt_q <= edgeCnt_q + 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_burst_start;
      burstStart;
   endsequence

   a_bus_load: assert property (cfgWr && addrW[`PRCFG_SEL_BIT] |=>
      bus_q == $past(addrW[15:0]) && $stable(ref_q)) else $error("bus setup load wrong");
   a_ref_load: assert property (cfgWr && !addrW[`PRCFG_SEL_BIT] |=>
      ref_q == $past(addrW[15:0]) && $stable(bus_q)) else $error("refresh setup load wrong");
   a_regs_hold: assert property (!cfgWr |=> $stable(bus_q) && $stable(ref_q))
      else $error("register changed without load");
   a_reg_read: assert property (regRead |=> !dqOeN &&
      dqOut == ($past(addrS[`PRCFG_SEL_BIT]) ? $past(bus_q) : $past(ref_q)))
      else $error("register read data wrong");
   a_cfg_no_array: assert property (cfgWr |=> !($rose(arrReqValid) && arrReqWrite))
      else $error("register load reached the array");
   a_array_write: assert property (arrAsyncWr && !reqValid_q |=>
      arrReqValid && arrReqWrite && arrReqAddr == $past(addrP)) else $error("array write lost");
   a_latency_count: assert property (state_q == BST_DATA && $past(state_q) == BST_LAT &&
      $past(latCode) >= 3'h2 |-> edgeCnt_q == 4'($past(latCode))) else $error("latency wrong");
   a_wrap_block: assert property (burstRdIssue && wrapOn |=>
      (burstAddr_q & ~$past(wrapMask)) == ($past(burstAddr_q) & ~$past(wrapMask)))
      else $error("wrapped burst left its block");
   a_seq_read: assert property (burstRdIssue && !wrapOn |=>
      burstAddr_q == $past(burstAddr_q) + 1'b1) else $error("sequential read address wrong");
   a_seq_write: assert property (burstWrPush |=> burstAddr_q == $past(burstAddr_q) + 1'b1)
      else $error("write burst address wrong");
   a_wait_level: assert property (s_burst_start |=> waitOut == $past(bus_q[`PRCFG_WAITPOL_BIT]))
      else $error("wait not asserted at burst start");
   a_async_idle: assert property (!syncMode && state_q == BST_IDLE |=> state_q == BST_IDLE)
      else $error("burst started in asynchronous mode");
endmodule : prcfg_top
